/* File: include/mux_scan_pkg.sv */
// constants, types and field layout for the mux scan sequencer
// ==========================================================================
// Function
// - scan mode when high low, low high
// - scan ignores address; config transparent or held
// - single-ended scan steps all eight channels
// - differential scan steps four adjacent pairs
// - each conversion uses current differential level
// - low mode change clears scan counter
// - start on falling edge; advance one/two
// - address outputs show converted channel, result
// - sixteen by seven sequencer memory with flag
// - program mode: memory access, busy low
// - any mode change resets pointer to zero
// - rising write edge stores and advances pointer
// - last written location carries end flag
// - pointer wraps; later writes start new sequence
// - readback drives seven bits, rest high impedance
// - rising read edge releases pins, advances pointer
// - final location reads end flag one
// - leaving program mode releases busy high
// - run: start converts entry, then pointer advances
// - run outputs show channel, not pointer
// - after end-flag entry pointer returns zero
// - memory persists across all mode changes
// - busy low during conversion, no restart
// - direct mode when both mode pins low
package mux_scan_pkg;

  // ========================================================================
  // register map (byte addresses on the apb side)
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [11:0] LAST_OFFSET   = 12'h008;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0001;
  localparam int          CTRL_ENABLE   = 0;

  // ========================================================================
  // conversion timing
  localparam int CONV_TIME_NS  = 1400;
  localparam int CLK_PERIOD_NS = 20;
  localparam int CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] CONV_LAST = 7'(CONV_CYCLES - 1);

  // ========================================================================
  // sequencer memory layout: {differential_select, addr[2:0], polarity, gain, end flag}
  localparam int SEQ_DEPTH  = 16;
  localparam int SEQ_WIDTH  = 7;
  localparam int CFG_WIDTH  = 6;
  localparam int S_EOS      = 0;
  localparam int S_GAIN     = 1;
  localparam int S_POL      = 2;
  localparam int S_ADDR_LO  = 3;
  localparam int S_DIFFERENTIAL_SELECT     = 6;
  localparam logic [3:0] PTR_RESET  = 4'h0;
  localparam logic [2:0] SCAN_RESET = 3'h0;

  // ========================================================================
  // modes, coded as {mode_select_high, mode_select_low}
  typedef enum logic [1:0] {
    MODE_DIRECT  = 2'b00,
    MODE_SCAN    = 2'b01,
    MODE_PROGRAM = 2'b10,
    MODE_RUN     = 2'b11
  } mode_type;

  typedef enum logic {
    CONV_IDLE = 1'b0,
    CONV_BUSY = 1'b1
  } conv_state_type;

endpackage

/* File: include/seq_mem_if.sv */
// carrier between the sequencer control and the sequencer memory
`timescale 1ns/1ps
interface seq_mem_if;
  logic       write_stb;  // store wdata at pointer, advance
  logic       read_adv;   // readback advance
  logic       run_adv;    // run advance, wraps on end flag
  logic       clear_ptr;  // mode change
  logic [5:0] wdata;
  logic [3:0] ptr;
  logic [6:0] rdata;

  modport mem  (input write_stb, read_adv, run_adv, clear_ptr, wdata,
                output ptr, rdata);
  modport ctrl (output write_stb, read_adv, run_adv, clear_ptr, wdata,
                input ptr, rdata);
endinterface

/* File: rtl/adc_mux_scan_sequencer.sv */
// channel selection control: direct, scan, program, readback and run modes
`timescale 1ns/1ps
module adc_mux_scan_sequencer (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic [11:0]           paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // mode select pins
  input  wire logic                  mode_select_high,
  input  wire logic                  mode_select_low,
  // strobes
  input  wire logic                  convert_start_n,
  input  wire logic                  write_strobe_n,
  input  wire logic                  read_strobe_n,
  // configuration pins
  input  wire logic                  differential_select,
  input  wire logic                  gain_range_select,
  input  wire logic                  polarity_select,
  input  wire logic [2:0]            channel_address_in,
  // converter core result
  input  wire logic [11:0]           sample_result,
  // analog mux steering
  output logic      [2:0]            mux_channel,
  output logic                       mux_differential,
  output logic                       mux_gain,
  output logic                       mux_polarity,
  output logic                       conversion_active,
  // host side pins
  output logic                       busy_n,
  output logic                       differential_flag_out,
  output logic      [2:0]            channel_address_out,
  output logic      [11:0]           data_out,
  output logic      [11:0]           data_oe
);
  import mux_scan_pkg::*;

  // ==========================================================================
  // declarations
  seq_mem_if             seq ();
  mode_type              mode;
  conv_state_type        conv_state_ff;
  logic                  high_prev_ff;
  logic                  low_prev_ff;
  logic                  cs_prev_ff;
  logic                  wr_prev_ff;
  logic                  rd_prev_ff;
  logic                  mode_change;
  logic                  low_change;
  logic                  start;
  logic                  done;
  logic [6:0]            conv_cnt_ff;
  logic [2:0]            scan_cnt_ff;
  logic [CFG_WIDTH-1:0]  cfg_ff;
  logic [CFG_WIDTH-1:0]  cfg_eff;
  logic [CFG_WIDTH-1:0]  nxt_conv_cfg;
  logic [CFG_WIDTH-1:0]  conv_cfg_ff;
  logic [11:0]           result_ff;
  logic [CFG_WIDTH-1:0]  last_cfg_ff;
  logic                  rb_drive_ff;
  logic [31:0]           ctrl_ff;
  logic [31:0]           prdata_ff;
  logic                  pready_ff;
  logic                  pslverr_ff;
  logic                  busy_n_ff;
  logic                  differential_flag_out_ff;
  logic [2:0]            addr_out_ff;
  logic [11:0]           data_out_ff;
  logic [11:0]           data_oe_ff;
  logic                  apb_setup;

  // ==========================================================================
  // apb address decode, shared by the read and write paths
  function automatic logic [1:0] reg_index(input logic [11:0] addr);
    if (addr == CTRL_OFFSET) begin
      reg_index = 2'h0;
    end else if (addr == STATUS_OFFSET) begin
      reg_index = 2'h1;
    end else if (addr == LAST_OFFSET) begin
      reg_index = 2'h2;
    end else begin
      reg_index = 2'h3;
    end
  endfunction

  // ==========================================================================
  // sequencer memory
  seq_memory u_seq_memory (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (seq.mem)
  );

  // ==========================================================================
  // pin history; pins are synchronous, one stage gives a clean edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_prev_ff <= 1'b0;
      low_prev_ff  <= 1'b0;
      cs_prev_ff   <= 1'b1;
      wr_prev_ff   <= 1'b1;
      rd_prev_ff   <= 1'b1;
    end else begin
      high_prev_ff <= mode_select_high;
      low_prev_ff  <= mode_select_low;
      cs_prev_ff   <= convert_start_n;
      wr_prev_ff   <= write_strobe_n;
      rd_prev_ff   <= read_strobe_n;
    end
  end

  // mode decode and one pulse per mode pin change
  assign mode        = mode_type'({mode_select_high, mode_select_low});
  assign low_change  = mode_select_low ^ low_prev_ff;
  assign mode_change = low_change | (mode_select_high ^ high_prev_ff);

  // ==========================================================================
  // configuration pins: follow while the write strobe is low, held after
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff <= '0;
    end else if (!write_strobe_n) begin
      cfg_ff <= {differential_select, channel_address_in,
                 polarity_select, gain_range_select};
    end
  end

  // while the strobe is low the pins act directly, without the hold delay
  assign cfg_eff = write_strobe_n ? cfg_ff
                 : {differential_select, channel_address_in,
                    polarity_select, gain_range_select};

  // ==========================================================================
  // conversion start: falling convert strobe, idle, not in program mode
  assign start = cs_prev_ff && !convert_start_n && (conv_state_ff == CONV_IDLE)
              && (mode != MODE_PROGRAM) && ctrl_ff[CTRL_ENABLE];
  assign done  = (conv_state_ff == CONV_BUSY) && (conv_cnt_ff == 7'h00);

  // channel and configuration chosen at the start, per mode
  always_comb begin
    nxt_conv_cfg = cfg_eff;
    case (mode)
      MODE_SCAN: begin
        // address pins ignored; pairs take the even channel as the plus side
        nxt_conv_cfg[4:2] = cfg_eff[5] ? {scan_cnt_ff[2:1], 1'b0}
                                       : scan_cnt_ff;
      end
      MODE_RUN: begin
        nxt_conv_cfg = seq.rdata[SEQ_WIDTH-1:1];
      end
      default: begin
        nxt_conv_cfg = cfg_eff;
      end
    endcase
  end

  // ==========================================================================
  // conversion state and timer; no restart while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_state_ff <= CONV_IDLE;
      conv_cnt_ff   <= 7'h00;
    end else begin
      case (conv_state_ff)
        CONV_IDLE: begin
          if (start) begin
            conv_state_ff <= CONV_BUSY;
            conv_cnt_ff   <= CONV_LAST;
          end
        end
        CONV_BUSY: begin
          if (done) begin
            conv_state_ff <= CONV_IDLE;
          end else begin
            conv_cnt_ff <= conv_cnt_ff - 7'h01;
          end
        end
        default: begin
          conv_state_ff <= CONV_IDLE;
        end
      endcase
    end
  end

  // configuration captured at the start drives the analog mux all conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_cfg_ff <= '0;
    end else if (start) begin
      conv_cfg_ff <= nxt_conv_cfg;
    end
  end

  // ==========================================================================
  // scan counter: cleared on low mode pin change, advanced after conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_cnt_ff <= SCAN_RESET;
    end else if (low_change) begin
      scan_cnt_ff <= SCAN_RESET;
    end else if (done && (mode == MODE_SCAN)) begin
      // step follows the differential level this conversion used
      scan_cnt_ff <= conv_cfg_ff[5] ? scan_cnt_ff + 3'h2
                                    : scan_cnt_ff + 3'h1;
    end
  end

  // ==========================================================================
  // sequencer strobes
  assign seq.clear_ptr = mode_change;
  assign seq.write_stb = (mode == MODE_PROGRAM) && !wr_prev_ff && write_strobe_n
                      && read_strobe_n && !mode_change;
  assign seq.read_adv  = (mode == MODE_PROGRAM) && !rd_prev_ff && read_strobe_n
                      && write_strobe_n && !mode_change;
  assign seq.run_adv   = done && (mode == MODE_RUN);
  assign seq.wdata     = cfg_ff;

  // readback drive flag: falling read strobe enables, rising releases
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rb_drive_ff <= 1'b0;
    end else if (mode != MODE_PROGRAM) begin
      rb_drive_ff <= 1'b0;
    end else if (rd_prev_ff && !read_strobe_n && write_strobe_n) begin
      rb_drive_ff <= 1'b1;
    end else if (read_strobe_n) begin
      rb_drive_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // result and the channel it belongs to, captured together at the end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_ff   <= 12'h000;
      last_cfg_ff <= '0;
    end else if (done) begin
      result_ff   <= sample_result;
      last_cfg_ff <= conv_cfg_ff;
    end
  end

  // ==========================================================================
  // host pins, all from flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_n_ff   <= 1'b1;
      differential_flag_out_ff <= 1'b0;
      addr_out_ff <= 3'h0;
      data_out_ff <= 12'h000;
      data_oe_ff  <= 12'h000;
    end else begin
      // program mode holds busy low; leaving it releases busy
      busy_n_ff <= !((mode == MODE_PROGRAM) || start
                  || ((conv_state_ff == CONV_BUSY) && !done));
      if (rb_drive_ff) begin
        // readback: seven stored bits on differential flag, address and top data pins only
        differential_flag_out_ff <= seq.rdata[S_DIFFERENTIAL_SELECT];
        addr_out_ff <= seq.rdata[S_DIFFERENTIAL_SELECT-1:S_ADDR_LO];
        data_out_ff <= {seq.rdata[S_POL:S_EOS], 9'h000};
        data_oe_ff  <= 12'he00;
      end else begin
        differential_flag_out_ff <= last_cfg_ff[5];
        addr_out_ff <= last_cfg_ff[4:2];
        data_out_ff <= result_ff;
        data_oe_ff  <= (mode == MODE_PROGRAM || read_strobe_n) ? 12'h000 : 12'hfff;
      end
    end
  end

  // ==========================================================================
  // apb slave: answers in the first access cycle, no wait states
  assign apb_setup = psel && !penable && !pready_ff;

  // control register: convert enable gates acceptance of the start strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RESET;
    end else if (psel && penable && pready_ff && pwrite && (reg_index(paddr) == 2'h0)) begin
      ctrl_ff <= {31'h0000_0000, pwdata[CTRL_ENABLE]};
    end
  end

  // read data, ready and error, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else if (apb_setup) begin
      pready_ff  <= 1'b1;
      pslverr_ff <= (reg_index(paddr) == 2'h3);
      prdata_ff  <= 32'h0000_0000;
      if (!pwrite) begin
        case (reg_index(paddr))
          2'h0: prdata_ff <= ctrl_ff;
          2'h1: prdata_ff <= {19'h00000, scan_cnt_ff, seq.ptr, mode,
                              conv_state_ff, !busy_n_ff, rb_drive_ff, seq.rdata[S_EOS]};
          2'h2: prdata_ff <= {14'h0000, last_cfg_ff, result_ff};
          default: prdata_ff <= 32'h0000_0000;
        endcase
      end
    end else begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // output wiring
  assign prdata                = prdata_ff;
  assign pready                = pready_ff;
  assign pslverr               = pslverr_ff;
  assign busy_n                = busy_n_ff;
  assign differential_flag_out = differential_flag_out_ff;
  assign channel_address_out   = addr_out_ff;
  assign data_out              = data_out_ff;
  assign data_oe               = data_oe_ff;
  assign mux_channel           = conv_cfg_ff[4:2];
  assign mux_differential      = conv_cfg_ff[5];
  assign mux_polarity          = conv_cfg_ff[1];
  assign mux_gain              = conv_cfg_ff[0];
  assign conversion_active     = (conv_state_ff == CONV_BUSY);
endmodule

/* File: rtl/seq_memory.sv */
// sixteen by seven sequencer memory with its pointer
`timescale 1ns/1ps
module seq_memory (
  // clock and reset
  input wire logic   pclk,
  input wire logic   presetn,
  // control side
  seq_mem_if.mem     bus
);
  import mux_scan_pkg::*;

  logic [CFG_WIDTH-1:0] data_ff [SEQ_DEPTH];
  logic [SEQ_DEPTH-1:0] eos_ff;
  logic [3:0]           ptr_ff;

  // ==========================================================================
  // pointer: clear has priority; natural 4-bit wrap after sixteen steps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_ff <= PTR_RESET;
    end else if (bus.clear_ptr) begin
      ptr_ff <= PTR_RESET;
    end else if (bus.write_stb || bus.read_adv) begin
      ptr_ff <= ptr_ff + 4'h1;
    end else if (bus.run_adv) begin
      ptr_ff <= eos_ff[ptr_ff] ? PTR_RESET : ptr_ff + 4'h1;
    end
  end

  // ==========================================================================
  // storage: only writes touch it, so contents survive every mode change
  for (genvar i = 0; i < SEQ_DEPTH; i++) begin : g_loc
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        data_ff[i] <= '0;
        eos_ff[i]  <= 1'b0;
      end else if (bus.write_stb) begin
        // a write at location zero opens a new sequence and erases the rest
        if (bus.ptr == 4'(i)) begin
          data_ff[i] <= bus.wdata;
        end else if (ptr_ff == PTR_RESET) begin
          data_ff[i] <= '0;
        end
        eos_ff[i] <= (ptr_ff == 4'(i));
      end
    end
  end

  assign bus.ptr   = ptr_ff;
  assign bus.rdata = {data_ff[ptr_ff], eos_ff[ptr_ff]};
endmodule

/* File: sim/adc_mux_scan_sequencer_assertions.sv */
// port-level checker for the mux scan sequencer
`timescale 1ns/1ps
module adc_mux_scan_sequencer_assertions
  import mux_scan_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb answer
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins
  input wire logic        mode_select_high,
  input wire logic        mode_select_low,
  input wire logic        convert_start_n,
  input wire logic        read_strobe_n,
  input wire logic        conversion_active,
  input wire logic        busy_n,
  input wire logic [11:0] data_out,
  input wire logic [11:0] data_oe
);
  logic [6:0] act_cnt_ff;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ======================================================================
  // conversion length; a counter since the figure is too long to unroll
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      act_cnt_ff <= 7'h00;
    else
      act_cnt_ff <= conversion_active ? act_cnt_ff + 7'h01 : 7'h00;
  end

  // ======================================================================
  // properties
  prog_busy_low_a: assert property ((mode_select_high && !mode_select_low)[*6] |-> !busy_n)
    else $error("busy high in program mode");
  no_prog_start_a: assert property ((mode_select_high && !mode_select_low)[*6]
    |-> !$rose(conversion_active)) else $error("conversion started in program mode");
  conv_length_a: assert property ($fell(conversion_active) |-> act_cnt_ff == 7'(CONV_CYCLES))
    else $error("conversion length wrong");
  busy_covers_a: assert property (conversion_active |-> !busy_n)
    else $error("busy high during conversion");
  start_cause_a: assert property ($rose(conversion_active) |-> !$past(convert_start_n)
    || !$past(convert_start_n, 2) || !$past(convert_start_n, 3))
    else $error("conversion without start strobe");
  busy_release_a: assert property ($rose(mode_select_low) && mode_select_high |-> ##[1:8] busy_n)
    else $error("busy not released after program mode");
  readback_oe_a: assert property (mode_select_high && !mode_select_low && data_oe != 12'h000
    |-> data_oe == 12'he00 && data_out[8:0] == 9'h000)
    else $error("readback drives low data pins");
  rd_release_a: assert property ($rose(read_strobe_n) && mode_select_high && !mode_select_low
    |-> ##[1:4] data_oe == 12'h000) else $error("data pins not released");
  unmapped_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer malformed");
endmodule

bind adc_mux_scan_sequencer adc_mux_scan_sequencer_assertions
  adc_mux_scan_sequencer_assertions_i (.pclk, .presetn, .prdata, .pready, .pslverr,
  .mode_select_high, .mode_select_low, .convert_start_n, .read_strobe_n, .conversion_active,
  .busy_n, .data_out, .data_oe);

/* File: sim/adc_mux_scan_sequencer_tb_top.sv */
// self-checking bench for the mux scan sequencer
`timescale 1ns/1ps
module adc_mux_scan_sequencer_tb_top;
  import mux_scan_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, ok;
  logic        mode_select_high, mode_select_low, convert_start_n, write_strobe_n;
  logic        read_strobe_n, differential_select, gain_range_select, polarity_select;
  logic        busy_n, differential_flag_out, mux_differential;
  logic [2:0]  channel_address_in, channel_address_out, cnt, mux_channel;
  logic [11:0] paddr, sample_result, data_out, data_oe;
  logic [31:0] pwdata, prdata, r;
  logic [5:0]  mem [16];
  logic [5:0]  c;
  int          n_fail, checks_done, seed, i, t, n, len;

  adc_mux_scan_sequencer adc_mux_scan_sequencer_i (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .mode_select_high, .mode_select_low, .convert_start_n, .write_strobe_n, .read_strobe_n,
    .differential_select, .gain_range_select, .polarity_select, .channel_address_in,
    .sample_result, .mux_channel, .mux_differential, .mux_gain(), .mux_polarity(),
    .conversion_active(), .busy_n, .differential_flag_out, .channel_address_out, .data_out,
    .data_oe);

  host_pins_model host_pins_model_i (
    .pclk, .busy_n, .mode_select_high, .mode_select_low, .convert_start_n, .write_strobe_n,
    .read_strobe_n, .differential_select, .gain_range_select, .polarity_select,
    .channel_address_in);

  // ======================================================================
  // clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    give_verdict();
  end

  // ======================================================================
  // expectations and checks
  function automatic logic [2:0] scan_addr(input logic [2:0] k, input logic dif);
    return dif ? {k[2:1], 1'b0} : k;  // pairs start on the even input
  endfunction
  function automatic logic [6:0] status_word(input int idx, input logic [5:0] w);
    return (idx < len) ? {w, 1'(idx == len - 1)} : 7'h00;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conv_check(input logic [3:0] exp_addr, input logic [11:0] res);
    @(negedge pclk);
    chk(32'({differential_flag_out, channel_address_out}), 32'(exp_addr));
    chk(32'(data_out), 32'(res));
    chk(32'({mux_differential, mux_channel}), 32'(exp_addr));
  endtask

  // one apb transfer: setup, then access until pready at a rising edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge pclk);
    {psel, penable, paddr, pwrite, pwdata} <= {2'b10, a, w, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge pclk);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ======================================================================
  // main sequence
  initial begin
    seed = 83;
    n_fail = 0;
    checks_done = 0;
    {psel, penable, pwrite, paddr, pwdata, sample_result} = '0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // register reset value, unmapped place, start refused while disabled
    apb(CTRL_OFFSET, 1'b0, 32'h0);
    chk(r, CTRL_RESET);
    apb(12'h00c, 1'b0, 32'h0);
    chk({e, r[30:0]}, 32'h8000_0000);
    apb(CTRL_OFFSET, 1'b1, 32'h0);
    host_pins_model_i.set_mode(2'b01);
    host_pins_model_i.convert(6'h00, ok);
    chk(32'(ok), 32'h0);
    apb(CTRL_OFFSET, 1'b1, CTRL_RESET);
    // scan, counter restarted by the mode change, random differential level
    host_pins_model_i.set_mode(2'b00);
    host_pins_model_i.set_mode(2'b01);
    cnt = 3'h0;
    for (i = 0; i < 12; i++) begin
      c = 6'($random(seed));
      @(posedge pclk);
      sample_result <= 12'($random(seed));
      host_pins_model_i.convert(c, ok);
      conv_check({c[5], scan_addr(cnt, c[5])}, sample_result);
      cnt = cnt + (c[5] ? 3'h2 : 3'h1);
    end
    // program a short and an overflowing sequence, read back, run it
    for (t = 0; t < 2; t++) begin
      n = t ? 17 : 5;
      len = (n > 16) ? n - 16 : n;
      host_pins_model_i.set_mode(2'b10);
      @(negedge pclk);
      chk(32'(busy_n), 32'h0);
      for (i = 0; i < n; i++) begin
        c = 6'($random(seed));
        mem[i % 16] = c;
        host_pins_model_i.write_loc(c);
      end
      host_pins_model_i.set_mode(2'b11);
      host_pins_model_i.set_mode(2'b10);
      for (i = 0; i < 17; i++) begin
        host_pins_model_i.rd_level(1'b0);
        @(negedge pclk);
        r = 32'(status_word(i % 16, mem[i % 16]));
        chk(32'({differential_flag_out, channel_address_out, data_out[11:9]}), r);
        chk(32'(data_oe), 32'he00);
        host_pins_model_i.rd_level(1'b1);
      end
      host_pins_model_i.set_mode(2'b11);
      @(negedge pclk);
      chk(32'(busy_n), 32'h1);
      for (i = 0; i < len + 2; i++) begin
        @(posedge pclk);
        sample_result <= 12'($random(seed));
        host_pins_model_i.convert(6'($random(seed)), ok);
        conv_check(mem[i % len][5:2], sample_result);
      end
    end
    // away to scan and back: the stored sequence survives, pointer at zero
    host_pins_model_i.set_mode(2'b01);
    host_pins_model_i.set_mode(2'b11);
    host_pins_model_i.convert(6'h3f, ok);
    conv_check(mem[0][5:2], sample_result);
    give_verdict();
  end
endmodule

/* File: sim/host_pins_model.sv */
// host processor model driving the mode, strobe and configuration pins
`timescale 1ns/1ps
module host_pins_model (
  // clock and device status
  input  wire logic  pclk,
  input  wire logic  busy_n,
  // mode and strobes
  output logic       mode_select_high,
  output logic       mode_select_low,
  output logic       convert_start_n,
  output logic       write_strobe_n,
  output logic       read_strobe_n,
  // configuration pins
  output logic       differential_select,
  output logic       gain_range_select,
  output logic       polarity_select,
  output logic [2:0] channel_address_in
);
  // ======================================================================
  // idle pins at time zero
  initial begin
    {mode_select_high, mode_select_low} = 2'b00;
    {convert_start_n, write_strobe_n, read_strobe_n} = 3'b111;
    put_cfg(6'h00);
  end

  task automatic ticks(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // config word is {differential_select, address, polarity, gain}
  task automatic put_cfg(input logic [5:0] c);
    {differential_select, channel_address_in, polarity_select, gain_range_select} <= c;
  endtask

  // the device registers the mode pins once for change detection, so give it edges to settle
  task automatic set_mode(input logic [1:0] m);
    @(posedge pclk);
    {mode_select_high, mode_select_low} <= m;
    ticks(6);
  endtask

  // pins before the strobe; afterwards they change so stale values show
  task automatic write_loc(input logic [5:0] c);
    @(posedge pclk);
    put_cfg(c);
    ticks(2);
    write_strobe_n <= 1'b0;
    ticks(3);
    write_strobe_n <= 1'b1;
    ticks(3);
    put_cfg(~c);
  endtask

  task automatic rd_level(input logic v);
    @(posedge pclk);
    read_strobe_n <= v;
    ticks(4);
  endtask

  // start one conversion; took tells whether busy went low
  task automatic convert(input logic [5:0] c, output logic took);
    int k;
    @(posedge pclk);
    put_cfg(c);
    write_strobe_n <= 1'b0;
    ticks(2);
    convert_start_n <= 1'b0;
    for (k = 0; k < 8 && busy_n; k++) @(negedge pclk);
    took = !busy_n;
    @(posedge pclk);
    convert_start_n <= 1'b1;
    for (k = 0; k < 100 && !busy_n; k++) @(negedge pclk);
    ticks(3);
    write_strobe_n <= 1'b1;
  endtask
endmodule
